// >>> hdl/dts_pkg.sv
// package: register layout, field positions and reset values of the thermal sensor status block
package dts_pkg;
   // model-specific register selectors (no offsets printed; index chosen locally)
   localparam logic [1:0] DTS_SEL_STATUS = 2'h0;
   localparam logic [1:0] DTS_SEL_INTCTL = 2'h1;
   // identification leaf fields
   localparam logic [7:0] DTS_ID_LEAF = 8'h06;
   localparam logic [3:0] DTS_NUM_THRESH = 4'h2;
   // status register bit positions
   localparam int DTS_ST_HOT = 0;
   localparam int DTS_ST_HOT_LOG = 1;
   localparam int DTS_ST_EXT = 2;
   localparam int DTS_ST_EXT_LOG = 3;
   localparam int DTS_ST_CRIT = 4;
   localparam int DTS_ST_CRIT_LOG = 5;
   localparam int DTS_ST_T1 = 6;
   localparam int DTS_ST_T1_LOG = 7;
   localparam int DTS_ST_T2 = 8;
   localparam int DTS_ST_T2_LOG = 9;
   localparam int DTS_ST_READ_LO = 16;
   localparam int DTS_ST_RES_LO = 27;
   localparam int DTS_ST_VALID = 31;
   // interrupt control bit positions
   localparam int DTS_IC_HIGH_EN = 0;
   localparam int DTS_IC_LOW_EN = 1;
   localparam int DTS_IC_HOT_EN = 2;
   localparam int DTS_IC_FORCE_EN = 3;
   localparam int DTS_IC_CRIT_EN = 4;
   localparam int DTS_IC_T1_LO = 8;
   localparam int DTS_IC_T1_DIS = 15;
   localparam int DTS_IC_T2_LO = 16;
   localparam int DTS_IC_T2_DIS = 23;
   // reset value of the interrupt control register: all enables off
   localparam logic [63:0] DTS_IC_RESET = 64'h0000_0000_0080_8000;
   localparam logic [63:0] DTS_IC_MASK = 64'h0000_0000_00FF_FF1F;

   // sensor inputs travel together
   typedef struct packed {
      logic hot;
      logic platHot;
      logic forcedThrottle;
      logic crit;
      logic valid;
      logic [6:0] readout;
      logic [3:0] resolution;
   } dts_sense_t;

   // register access request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [1:0] sel;
      logic [63:0] wdata;
   } dts_req_t;
endpackage

// >>> hdl/dts_sensor_status.sv
// thermal sensor status, threshold compare and thermal interrupt request logic
`timescale 1ns/1ps
module dts_sensor_status (
   input wire logic clk,
   input wire logic rst,
   input dts_pkg::dts_sense_t sense,
   input wire logic bidirHotEn,
   input dts_pkg::dts_req_t req,
   input wire logic [7:0] idLeaf,
   output logic [63:0] rdata_q,
   output logic rvalid_q,
   output logic idSupport_q,
   output logic [3:0] idThreshCount_q,
   output logic thermIrq_q
);
   import dts_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // smaller readout means hotter, so "at or above" is readout <= value
   function automatic logic atOrAbove(input logic [6:0] rd, input logic [6:0] th);
      atOrAbove = (rd <= th);
   endfunction

   // zero-write clear of a sticky bit, unless a set arrives the same cycle
   function automatic logic stickyNext(input logic cur, input logic setEv, input logic clrEv);
      stickyNext = setEv | (cur & ~clrEv);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // live conditions

   logic [63:0] intCtl_q;
   logic hotLog_q, extLog_q, critLog_q, t1Log_q, t2Log_q;
   logic hotPrev_q, extHotPrev_q, forcePrev_q, critPrev_q, t1Prev_q, t2Prev_q;
   logic extHot, extAny, t1Now, t2Now, stWr;
   logic [6:0] readout;

   // readout is saturated at zero by the sensor itself; hotter goes to crit
   assign readout = sense.readout;
   assign extHot = sense.platHot & bidirHotEn;
   assign extAny = sense.platHot | sense.forcedThrottle;
   // compare only while the reading is meaningful, else stale data would set logs
   assign t1Now = sense.valid & atOrAbove(readout, intCtl_q[DTS_IC_T1_LO +: 7]);
   assign t2Now = sense.valid & atOrAbove(readout, intCtl_q[DTS_IC_T2_LO +: 7]);
   assign stWr = req.wr & (req.sel == DTS_SEL_STATUS);

   ////////////////////////////////////////////////////////////////////////
   // interrupt control register

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         intCtl_q <= DTS_IC_RESET;
      end else if (req.wr && req.sel == DTS_SEL_INTCTL) begin
         intCtl_q <= req.wdata & DTS_IC_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky log bits; a one written leaves them alone

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hotLog_q <= 1'b0;
         extLog_q <= 1'b0;
         critLog_q <= 1'b0;
         t1Log_q <= 1'b0;
         t2Log_q <= 1'b0;
      end else begin
         hotLog_q <= stickyNext(hotLog_q, sense.hot,
                                stWr & ~req.wdata[DTS_ST_HOT_LOG]);
         extLog_q <= stickyNext(extLog_q, extHot | sense.forcedThrottle,
                                stWr & ~req.wdata[DTS_ST_EXT_LOG]);
         critLog_q <= stickyNext(critLog_q, sense.crit,
                                 stWr & ~req.wdata[DTS_ST_CRIT_LOG]);
         t1Log_q <= stickyNext(t1Log_q, t1Now, stWr & ~req.wdata[DTS_ST_T1_LOG]);
         t2Log_q <= stickyNext(t2Log_q, t2Now, stWr & ~req.wdata[DTS_ST_T2_LOG]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // previous values for edge detection

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hotPrev_q <= 1'b0;
         extHotPrev_q <= 1'b0;
         forcePrev_q <= 1'b0;
         critPrev_q <= 1'b0;
         t1Prev_q <= 1'b0;
         t2Prev_q <= 1'b0;
      end else begin
         hotPrev_q <= sense.hot;
         extHotPrev_q <= extHot;
         forcePrev_q <= sense.forcedThrottle;
         critPrev_q <= sense.crit;
         t1Prev_q <= t1Now;
         t2Prev_q <= t2Now;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // single shared thermal interrupt request

   logic irqD;
   always_comb begin
      irqD = 1'b0;
      if (intCtl_q[DTS_IC_HIGH_EN] && sense.hot && !hotPrev_q) irqD = 1'b1;
      if (intCtl_q[DTS_IC_LOW_EN] && !sense.hot && hotPrev_q) irqD = 1'b1;
      if (intCtl_q[DTS_IC_HOT_EN] && extHot && !extHotPrev_q) irqD = 1'b1;
      if (intCtl_q[DTS_IC_FORCE_EN] && sense.forcedThrottle && !forcePrev_q) irqD = 1'b1;
      if (intCtl_q[DTS_IC_CRIT_EN] && sense.crit && !critPrev_q) irqD = 1'b1;
      if (!intCtl_q[DTS_IC_T1_DIS] && (t1Now != t1Prev_q)) irqD = 1'b1;
      if (!intCtl_q[DTS_IC_T2_DIS] && (t2Now != t2Prev_q)) irqD = 1'b1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         thermIrq_q <= 1'b0;
      end else begin
         thermIrq_q <= irqD;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status word assembly and read port

   logic [63:0] statusWord;
   always_comb begin
      statusWord = 64'h0;
      statusWord[DTS_ST_HOT] = sense.hot;
      statusWord[DTS_ST_HOT_LOG] = hotLog_q;
      statusWord[DTS_ST_EXT] = extAny;
      statusWord[DTS_ST_EXT_LOG] = extLog_q;
      statusWord[DTS_ST_CRIT] = sense.crit;
      statusWord[DTS_ST_CRIT_LOG] = critLog_q;
      statusWord[DTS_ST_T1] = t1Now;
      statusWord[DTS_ST_T1_LOG] = t1Log_q;
      statusWord[DTS_ST_T2] = t2Now;
      statusWord[DTS_ST_T2_LOG] = t2Log_q;
      statusWord[DTS_ST_READ_LO +: 7] = readout;
      statusWord[DTS_ST_RES_LO +: 4] = sense.resolution;
      statusWord[DTS_ST_VALID] = sense.valid;
   end

   // reads answer one cycle later; unknown selectors read as zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 64'h0;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= req.rd;
         if (req.rd && req.sel == DTS_SEL_STATUS) begin
            rdata_q <= statusWord;
         end else if (req.rd && req.sel == DTS_SEL_INTCTL) begin
            rdata_q <= intCtl_q;
         end else if (req.rd) begin
            rdata_q <= 64'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // identification leaf answer; threshold count shown only for the sensor leaf

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         idSupport_q <= 1'b0;
         idThreshCount_q <= 4'h0;
      end else begin
         idSupport_q <= (idLeaf == DTS_ID_LEAF);
         idThreshCount_q <= (idLeaf == DTS_ID_LEAF) ? DTS_NUM_THRESH : 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   property p_hotLogSet;
      @(posedge clk) disable iff (rst) sense.hot |=> hotLog_q;
   endproperty
   a_hotLogSet: assert property (p_hotLogSet) else $error("hot log not set");

   property p_logClear;
      @(posedge clk) disable iff (rst)
         stWr && !req.wdata[DTS_ST_CRIT_LOG] && !sense.crit |=> !critLog_q;
   endproperty
   a_logClear: assert property (p_logClear) else $error("crit log not cleared");

   property p_logKeep;
      @(posedge clk) disable iff (rst)
         t1Log_q && !(stWr && !req.wdata[DTS_ST_T1_LOG]) |=> t1Log_q;
   endproperty
   a_logKeep: assert property (p_logKeep) else $error("t1 log dropped");

   property p_t2Log;
      @(posedge clk) disable iff (rst) t2Now |=> t2Log_q;
   endproperty
   a_t2Log: assert property (p_t2Log) else $error("t2 log not set");

   property p_extLog;
      @(posedge clk) disable iff (rst)
         sense.platHot && !bidirHotEn && !sense.forcedThrottle && !extLog_q
         && !stWr |=> !extLog_q;
   endproperty
   a_extLog: assert property (p_extLog) else $error("ext log set without bidir");

   property p_t1Irq;
      @(posedge clk) disable iff (rst)
         !intCtl_q[DTS_IC_T1_DIS] && (t1Now != t1Prev_q) |=> thermIrq_q;
   endproperty
   a_t1Irq: assert property (p_t1Irq) else $error("t1 crossing irq missing");

   property p_irqPulse;
      @(posedge clk) disable iff (rst)
         thermIrq_q && $stable(sense) && $stable(intCtl_q) |=> !thermIrq_q;
   endproperty
   a_irqPulse: assert property (p_irqPulse) else $error("irq not one cycle");

   property p_highIrq;
      @(posedge clk) disable iff (rst)
         intCtl_q[DTS_IC_HIGH_EN] && $rose(sense.hot) |=> thermIrq_q;
   endproperty
   a_highIrq: assert property (p_highIrq) else $error("high temp irq missing");

   property p_critIrq;
      @(posedge clk) disable iff (rst)
         intCtl_q[DTS_IC_CRIT_EN] && $rose(sense.crit) |=> thermIrq_q;
   endproperty
   a_critIrq: assert property (p_critIrq) else $error("crit irq missing");

   property p_readStatus;
      @(posedge clk) disable iff (rst)
         req.rd && req.sel == DTS_SEL_STATUS
         |=> rvalid_q && rdata_q[DTS_ST_HOT] == $past(sense.hot);
   endproperty
   a_readStatus: assert property (p_readStatus) else $error("status read wrong");

   property p_readExt;
      @(posedge clk) disable iff (rst) req.rd && req.sel == DTS_SEL_STATUS
         |=> rdata_q[DTS_ST_EXT] == $past(sense.platHot | sense.forcedThrottle);
   endproperty
   a_readExt: assert property (p_readExt) else $error("external status read wrong");

   property p_readField;
      @(posedge clk) disable iff (rst) req.rd && req.sel == DTS_SEL_STATUS
         |=> rdata_q[DTS_ST_READ_LO +: 7] == $past(sense.readout)
         && rdata_q[DTS_ST_RES_LO +: 4] == $past(sense.resolution);
   endproperty
   a_readField: assert property (p_readField) else $error("readout fields wrong");

   property p_readValid;
      @(posedge clk) disable iff (rst) req.rd && req.sel == DTS_SEL_STATUS
         |=> rdata_q[DTS_ST_VALID] == $past(sense.valid);
   endproperty
   a_readValid: assert property (p_readValid) else $error("valid flag wrong");

   // status compare written out directly so a broken helper function is caught
   property p_t1Status;
      @(posedge clk) disable iff (rst) req.rd && req.sel == DTS_SEL_STATUS
         |=> rdata_q[DTS_ST_T1]
             == $past(sense.valid && sense.readout <= intCtl_q[DTS_IC_T1_LO +: 7]);
   endproperty
   a_t1Status: assert property (p_t1Status) else $error("t1 status wrong");

   property p_lowIrq;
      @(posedge clk) disable iff (rst)
         intCtl_q[DTS_IC_LOW_EN] && $fell(sense.hot) |=> thermIrq_q;
   endproperty
   a_lowIrq: assert property (p_lowIrq) else $error("low temp irq missing");

   property p_hotIrq;
      @(posedge clk) disable iff (rst)
         intCtl_q[DTS_IC_HOT_EN] && bidirHotEn && $rose(sense.platHot) |=> thermIrq_q;
   endproperty
   a_hotIrq: assert property (p_hotIrq) else $error("platform hot irq missing");

   property p_forceIrq;
      @(posedge clk) disable iff (rst)
         intCtl_q[DTS_IC_FORCE_EN] && $rose(sense.forcedThrottle) |=> thermIrq_q;
   endproperty
   a_forceIrq: assert property (p_forceIrq) else $error("forced throttle irq missing");

   property p_t2Irq;
      @(posedge clk) disable iff (rst)
         !intCtl_q[DTS_IC_T2_DIS] && $changed(t2Now) |=> thermIrq_q;
   endproperty
   a_t2Irq: assert property (p_t2Irq) else $error("t2 crossing irq missing");

   property p_idAnswer;
      @(posedge clk) disable iff (rst)
         idLeaf == DTS_ID_LEAF |=> idSupport_q && idThreshCount_q == DTS_NUM_THRESH;
   endproperty
   a_idAnswer: assert property (p_idAnswer) else $error("identification answer wrong");

   c_t1Cross: cover property (@(posedge clk) disable iff (rst) $rose(t1Now) ##1 thermIrq_q);
   c_t2Cross: cover property (@(posedge clk) disable iff (rst) $changed(t2Now) ##1 thermIrq_q);
   c_forceIrq: cover property (@(posedge clk) disable iff (rst)
      $rose(sense.forcedThrottle) ##1 thermIrq_q);
   c_logClr: cover property (@(posedge clk) disable iff (rst) hotLog_q ##1 !hotLog_q);
   c_critIrq: cover property (@(posedge clk) disable iff (rst) $rose(sense.crit) ##1 thermIrq_q);
endmodule

// >>> verification/dts_platform_agent.sv
// model of another platform agent driving the shared hot and forced-throttle lines
`timescale 1ns/1ps
module dts_platform_agent #(
   parameter int HOLD = 4
) (
   input wire logic clk,
   input wire logic hotReq,
   input wire logic forceReq,
   output logic platHot,
   output logic forcedThrottle
);
   int hotCnt = 0;
   int forceCnt = 0;
   // each request holds its line for HOLD cycles; updates land as nba on the sampling edge
   always @(posedge clk) begin
      hotCnt <= hotReq ? HOLD : (hotCnt > 0 ? hotCnt - 1 : 0);
      forceCnt <= forceReq ? HOLD : (forceCnt > 0 ? forceCnt - 1 : 0);
   end
   // lines fall back to idle low once the hold runs out
   assign platHot = hotCnt > 0;
   assign forcedThrottle = forceCnt > 0;
endmodule

// >>> verification/tb.sv
// self-checking testbench for the thermal sensor status block
`timescale 1ns/1ps
module tb;
   import dts_pkg::*;
   typedef struct {logic hot; logic crit; logic valid; logic [6:0] ro; logic [63:0] exp;
      logic [63:0] msk;} dts_row_t;
   localparam logic [63:0] LIVE = 64'hFFFF_FFFF_FFFF_FD55;
   logic clk = 0, rst = 1, bidirHotEn = 0, hotReq = 0, forceReq = 0;
   logic hot = 0, crit = 0, valid = 0, platHot, forcedThrottle;
   logic [6:0] readout = 7'h00;
   logic [3:0] res = 4'h2;
   logic [7:0] idLeaf = 8'h00;
   logic [63:0] rdata_q, rd;
   logic rvalid_q, idSupport_q, thermIrq_q;
   logic [3:0] idThreshCount_q;
   dts_req_t req = '0;
   dts_sense_t sense;
   int miscompares = 0, cmp_count = 0, cycles = 0, irqs = 0, irqBase = 0;
   // valid-low row masks the readout field since it carries no measurement
   dts_row_t rows [6] = '{
      '{1'b0, 1'b0, 1'b0, 7'h1E, 64'h1000_0000, 64'hFFFF_FFFF_FF80_FD55},
      '{1'b0, 1'b0, 1'b1, 7'h1E, 64'h901E_0000, LIVE},
      '{1'b0, 1'b0, 1'b1, 7'h14, 64'h9014_0040, LIVE},
      '{1'b0, 1'b0, 1'b1, 7'h0B, 64'h900B_0040, LIVE},
      '{1'b1, 1'b0, 1'b1, 7'h0A, 64'h900A_0141, LIVE},
      '{1'b1, 1'b1, 1'b1, 7'h00, 64'h9000_0151, LIVE}};

   ////////////////////////////////////////////////////////////////////////////////////////////
   assign sense = '{hot, platHot, forcedThrottle, crit, valid, readout, res};
   always #25 clk = ~clk;
   dts_platform_agent dts_platform_agent_i (.clk(clk), .hotReq(hotReq), .forceReq(forceReq),
      .platHot(platHot), .forcedThrottle(forcedThrottle));
   dts_sensor_status dts_sensor_status_i (.clk(clk), .rst(rst), .sense(sense),
      .bidirHotEn(bidirHotEn), .req(req), .idLeaf(idLeaf), .rdata_q(rdata_q),
      .rvalid_q(rvalid_q), .idSupport_q(idSupport_q), .idThreshCount_q(idThreshCount_q),
      .thermIrq_q(thermIrq_q));
   // count interrupt pulses where they are settled, on the falling edge
   always @(negedge clk) if (thermIrq_q === 1'b1) irqs++;
   // hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic cmpReg(string what, logic [63:0] exp, logic [63:0] got, logic [63:0] msk);
      cmp_count++;
      if ((got & msk) !== (exp & msk)) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp & msk, got & msk);
      end
   endtask
   // interrupt pulses since the last check, after the source has had time to settle
   task automatic irq_exp(int n);
      repeat (6) @(negedge clk);
      cmp_count++;
      if (irqs - irqBase != n) begin
         miscompares++;
         $display("unexpected irq count: expected %0d seen %0d", n, irqs - irqBase);
      end
      irqBase = irqs;
   endtask
   task automatic reg_wr(logic [1:0] s, logic [63:0] d);
      @(negedge clk);
      req = '{rd: 1'b0, wr: 1'b1, sel: s, wdata: d};
      @(negedge clk);
      req = '0;
   endtask
   // read strobe lasts one cycle; the answer pulse must stand exactly one cycle later
   task automatic reg_rd(logic [1:0] s);
      @(negedge clk);
      req = '{rd: 1'b1, wr: 1'b0, sel: s, wdata: 64'h0};
      @(negedge clk);
      req = '0;
      cmpReg("read answer", 64'h1, {63'h0, rvalid_q}, '1);
      rd = rdata_q;
   endtask
   task automatic agent_pulse(logic h);
      @(negedge clk);
      hotReq = h;
      forceReq = ~h;
      @(negedge clk);
      hotReq = 0;
      forceReq = 0;
      reg_rd(DTS_SEL_STATUS);
   endtask
   task automatic finish_test();
      $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst = 0;
      reg_rd(DTS_SEL_INTCTL); cmpReg("intctl reset", DTS_IC_RESET, rd, '1);
      reg_rd(DTS_SEL_STATUS); cmpReg("status reset", 64'h1000_0000, rd, '1);
      reg_wr(DTS_SEL_INTCTL, '1);
      reg_rd(DTS_SEL_INTCTL); cmpReg("intctl all ones", DTS_IC_MASK, rd, '1);
      reg_rd(2'h3); cmpReg("unmapped", 64'h0, rd, '1);
      // thresholds 0x14 and 0x0A match row readouts; both threshold interrupts stay disabled, so crossings raise none
      reg_wr(DTS_SEL_INTCTL, 64'h008A_9400);
      irq_exp(0);
      foreach (rows[i]) begin
         {hot, crit, valid, readout} = {rows[i].hot, rows[i].crit, rows[i].valid, rows[i].ro};
         reg_rd(DTS_SEL_STATUS);
         cmpReg("status live", rows[i].exp, rd, rows[i].msk);
      end
      irq_exp(0);
      // writing ones keeps logs; a zero write loses to a source still held high
      reg_wr(DTS_SEL_STATUS, '1);
      reg_rd(DTS_SEL_STATUS); cmpReg("logs kept", 64'h3A3, rd, 64'h3AB);
      crit = 0;
      readout = 7'h1E;
      reg_wr(DTS_SEL_STATUS, 64'h0);
      reg_rd(DTS_SEL_STATUS); cmpReg("logs cleared", 64'h3, rd, 64'h3AB);
      hot = 0;
      reg_wr(DTS_SEL_INTCTL, 64'h0080_801C);
      irq_exp(0);
      agent_pulse(1'b1); cmpReg("ext log bidir off", 64'h0, rd, 64'h8);
      irq_exp(0);
      agent_pulse(1'b0); cmpReg("ext force", 64'hC, rd, 64'hC);
      irq_exp(1);
      reg_wr(DTS_SEL_STATUS, 64'h0);
      bidirHotEn = 1;
      agent_pulse(1'b1); cmpReg("ext hot", 64'hC, rd, 64'hC);
      irq_exp(1);
      crit = 1;
      irq_exp(1);
      reg_wr(DTS_SEL_INTCTL, 64'h0080_8001);
      hot = 1;
      irq_exp(1);
      hot = 0;
      irq_exp(0);
      reg_wr(DTS_SEL_INTCTL, 64'h0080_8002);
      hot = 1;
      irq_exp(0);
      hot = 0;
      irq_exp(1);
      reg_wr(DTS_SEL_INTCTL, 64'h0080_1400);
      readout = 7'h14;
      irq_exp(1);
      readout = 7'h19;
      irq_exp(1);
      reg_wr(DTS_SEL_INTCTL, 64'h000A_9400);
      readout = 7'h0A;
      irq_exp(1);
      idLeaf = 8'h06;
      repeat (2) @(negedge clk);
      cmpReg("id leaf", 64'h12, {59'h0, idSupport_q, idThreshCount_q}, '1);
      idLeaf = 8'h07;
      repeat (2) @(negedge clk);
      cmpReg("id other", 64'h0, {59'h0, idSupport_q, idThreshCount_q}, '1);
      // mid-run reset: outputs drop at once, enables and logs start over; crit still held
      rst = 1;
      @(negedge clk);
      cmpReg("rdata in reset", 64'h0, rdata_q, '1);
      cmpReg("flags in reset", 64'h0, {57'h0, rvalid_q, thermIrq_q, idSupport_q,
         idThreshCount_q}, '1);
      rst = 0;
      reg_rd(DTS_SEL_INTCTL); cmpReg("intctl after reset", DTS_IC_RESET, rd, '1);
      reg_rd(DTS_SEL_STATUS); cmpReg("logs after reset", 64'h20, rd, 64'h2AA);
      finish_test();
   end
endmodule
